// ---- hdl/pbsi_pkg.sv ----
// Shared constants for the pipelined burst static memory interface
package pbsi_pkg;
  localparam int PBSI_ADDR_W = 19;
  localparam int PBSI_LANES = 4;
  localparam int PBSI_LANE_W = 9;
  localparam int PBSI_DATA_W = PBSI_LANES * PBSI_LANE_W;
  localparam int PBSI_BURST_W = 2;
  localparam int PBSI_DEPTH = 1 << PBSI_ADDR_W;
  localparam logic [PBSI_BURST_W-1:0] PBSI_BURST_ONE = 2'h1;
  localparam logic [PBSI_BURST_W-1:0] PBSI_BURST_ZERO = 2'h0;
  localparam logic [PBSI_LANES-1:0] PBSI_ALL_LANES = 4'hF;
  localparam logic [PBSI_LANES-1:0] PBSI_NO_LANES = 4'h0;
  localparam int PBSI_SLEEP_SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    PBSI_ST_DESEL = 3'h1,
    PBSI_ST_ACTIVE = 3'h2,
    PBSI_ST_SLEEP = 3'h4
  } pbsi_state_type;

  // Internal write qualifier
  function automatic logic pbsi_write_qual(input logic gw_n, input logic bwe_n, input logic [PBSI_LANES-1:0] bw_n);
    pbsi_write_qual = !gw_n || (!bwe_n && (bw_n != PBSI_ALL_LANES));
  endfunction

  // Lanes to store; global write overrides lane selects
  function automatic logic [PBSI_LANES-1:0] pbsi_lane_mask(input logic gw_n, input logic bwe_n,
                                                            input logic [PBSI_LANES-1:0] bw_n);
    if (!gw_n) begin
      pbsi_lane_mask = PBSI_ALL_LANES;
    end else if (!bwe_n) begin
      pbsi_lane_mask = ~bw_n;
    end else begin
      pbsi_lane_mask = PBSI_NO_LANES;
    end
  endfunction
endpackage

// ---- hdl/pbsi_burst_counter.sv ----
// Two-bit wrapping burst counter, linear or interleaved order
`timescale 1ns/100ps
`default_nettype none
module pbsi_burst_counter
  import pbsi_pkg::*;
(
  // Clock
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Control
  input wire logic i_load,
  input wire logic [PBSI_BURST_W-1:0] i_start,
  input wire logic i_step,
  input wire logic i_interleaved,
  // Current low address bits
  output logic [PBSI_BURST_W-1:0] o_addr_low
);
  logic [PBSI_BURST_W-1:0] start_reg;
  logic [PBSI_BURST_W-1:0] seq_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      start_reg <= PBSI_BURST_ZERO;
      seq_reg <= PBSI_BURST_ZERO;
    end else if (i_ce) begin
      if (i_load) begin
        start_reg <= i_start;
        seq_reg <= PBSI_BURST_ZERO;
      end else if (i_step) begin
        seq_reg <= seq_reg + PBSI_BURST_ONE;
      end
    end
  end

  // Order input is used unregistered here so a change of order_reg takes effect on the current beat without waiting for a step
  always_comb begin
    if (i_interleaved) begin
      o_addr_low = start_reg ^ seq_reg;
    end else begin
      o_addr_low = start_reg + seq_reg;
    end
  end
endmodule // pbsi_burst_counter
`default_nettype wire

// ---- hdl/pbsi_mem_array.sv ----
// Byte-lane writable storage with a registered read port
`timescale 1ns/100ps
`default_nettype none
module pbsi_mem_array
  import pbsi_pkg::*;
(
  // Clock
  input wire logic i_clk,
  input wire logic i_ce,
  // Write port
  input wire logic [PBSI_LANES-1:0] i_lane_we,
  input wire logic [PBSI_ADDR_W-1:0] i_addr,
  input wire logic [PBSI_DATA_W-1:0] i_wdata,
  // Read port
  input wire logic i_rd_en,
  output logic [PBSI_DATA_W-1:0] o_rdata
);
  logic [PBSI_DATA_W-1:0] mem [PBSI_DEPTH];

  // Contents carry no reset so that sleep and reset both keep data
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      for (int l = 0; l < PBSI_LANES; l++) begin
        if (i_lane_we[l]) begin
          mem[i_addr][l*PBSI_LANE_W +: PBSI_LANE_W] <= i_wdata[l*PBSI_LANE_W +: PBSI_LANE_W];
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_ce && i_rd_en) begin
      o_rdata <= mem[i_addr];
    end
  end
endmodule // pbsi_mem_array
`default_nettype wire

// ---- hdl/pbsi_sram_if.sv ----
// Pipelined burst static memory bus interface, top level
//
// What this block does
// - Register all inputs except output enable, and read data outputs
// - Capture address only when a strobe active
// - Processor strobe ignored when chip select one high
// - Read when selected and write controls high
// - Read data driven after next edge
// - First cycle after deselect stays tri-stated
// - Deselect tri-states outputs after next edge
// - Processor strobe loads address, ignores write, step
// - Processor-strobe write completes at second edge
// - Byte write stores only selected lanes
// - Global write stores every lane
// - Controller-strobe write completes in one cycle
// - Drivers off whenever write cycle detected
// - Counter loads from two low address bits
// - Burst step advances counter, reads and writes
// - Order pin low linear, else interleaved
// - Sleep entry and exit take three cycles
// - Pending access dropped on sleep entry
// - Write qualifier from global and byte enables
// - Processor strobe start is always a read
// - Output enable asynchronous and masked on writes
`timescale 1ns/100ps
`default_nettype none
module pbsi_sram_if
  import pbsi_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Address and chip selects
  input wire logic [PBSI_ADDR_W-1:0] i_addr,
  input wire logic i_chip_sel1_n,
  input wire logic i_chip_sel2,
  input wire logic i_chip_sel3_n,
  // Burst control
  input wire logic i_processor_addr_strobe_n,
  input wire logic i_controller_addr_strobe_n,
  input wire logic i_burst_step_n,
  input wire logic i_burst_order,
  // Write controls
  input wire logic i_global_write_n,
  input wire logic i_byte_write_enable_n,
  input wire logic [PBSI_LANES-1:0] i_byte_lane_write_n,
  // Asynchronous controls
  input wire logic i_out_enable_n,
  input wire logic i_sleep_request,
  // Data pins
  input wire logic [PBSI_DATA_W-1:0] i_dq,
  output logic [PBSI_DATA_W-1:0] o_dq,
  output logic o_dq_oe,
  // Status
  output logic o_sleeping
);
  // Input registers
  logic [PBSI_ADDR_W-1:0] addr_reg;
  logic cs1_n_reg;
  logic cs2_reg;
  logic cs3_n_reg;
  logic pstrobe_n_reg;
  logic cstrobe_n_reg;
  logic step_n_reg;
  logic order_reg;
  logic gw_n_reg;
  logic bwe_n_reg;
  logic [PBSI_LANES-1:0] bw_n_reg;
  logic [PBSI_DATA_W-1:0] din_reg;
  logic sleep_meta_reg;
  logic sleep_sync_reg;

  // Control state
  pbsi_state_type state_reg;
  pbsi_state_type state_next;
  logic [PBSI_ADDR_W-1:PBSI_BURST_W] base_reg;
  logic rd_valid_reg;
  logic first_reg;
  logic wr_cycle_reg;

  // Decoded controls
  logic pstrobe_take;
  logic strobe;
  logic selected;
  logic wq;
  logic load;
  logic do_read;
  logic do_write;
  logic do_step;
  logic [PBSI_BURST_W-1:0] addr_low;
  logic [PBSI_ADDR_W-1:0] acc_addr;
  logic [PBSI_LANES-1:0] lane_we;
  logic [PBSI_DATA_W-1:0] rdata;

  // Address pins are taken every edge; the burst base keeps them only on a strobe
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      addr_reg <= '0;
    end else if (i_ce) begin
      addr_reg <= i_addr;
    end
  end

  // Chip selects reset to their deselected levels
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cs1_n_reg <= 1'h1;
      cs2_reg <= 1'h0;
      cs3_n_reg <= 1'h1;
    end else if (i_ce) begin
      cs1_n_reg <= i_chip_sel1_n;
      cs2_reg <= i_chip_sel2;
      cs3_n_reg <= i_chip_sel3_n;
    end
  end

  // Strobes reset inactive; order resets interleaved as for a floating pin
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pstrobe_n_reg <= 1'h1;
      cstrobe_n_reg <= 1'h1;
      step_n_reg <= 1'h1;
      order_reg <= 1'h1;
    end else if (i_ce) begin
      pstrobe_n_reg <= i_processor_addr_strobe_n;
      cstrobe_n_reg <= i_controller_addr_strobe_n;
      step_n_reg <= i_burst_step_n;
      order_reg <= i_burst_order;
    end
  end

  // Write controls reset high so the first decode never sees a write
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      gw_n_reg <= 1'h1;
      bwe_n_reg <= 1'h1;
      bw_n_reg <= PBSI_ALL_LANES;
    end else if (i_ce) begin
      gw_n_reg <= i_global_write_n;
      bwe_n_reg <= i_byte_write_enable_n;
      bw_n_reg <= i_byte_lane_write_n;
    end
  end

  // Write data from the shared pins
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      din_reg <= '0;
    end else if (i_ce) begin
      din_reg <= i_dq;
    end
  end

  // Sleep pin is asynchronous; the two stages plus the state register give the three-cycle entry and exit
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sleep_meta_reg <= 1'h0;
      sleep_sync_reg <= 1'h0;
    end else if (i_ce) begin
      sleep_meta_reg <= i_sleep_request;
      sleep_sync_reg <= sleep_meta_reg;
    end
  end

  // Registered strobe and select decode; a processor strobe needs chip select one low
  always_comb begin
    pstrobe_take = !pstrobe_n_reg && !cs1_n_reg;
    strobe = pstrobe_take || !cstrobe_n_reg;
    selected = !cs1_n_reg && cs2_reg && !cs3_n_reg;
    wq = pbsi_write_qual(gw_n_reg, bwe_n_reg, bw_n_reg);
  end

  // Next-state and access decode
  always_comb begin
    load = 1'h0;
    do_read = 1'h0;
    do_write = 1'h0;
    do_step = 1'h0;
    state_next = state_reg;
    case (state_reg)
      PBSI_ST_DESEL, PBSI_ST_ACTIVE: begin
        if (sleep_sync_reg) begin
          state_next = PBSI_ST_SLEEP;
        end else if (strobe && !selected) begin
          state_next = PBSI_ST_DESEL;
        end else if (strobe) begin
          state_next = PBSI_ST_ACTIVE;
          load = 1'h1;
          if (pstrobe_take) begin
            do_read = 1'h1;
          end else begin
            do_write = wq;
            do_read = !wq;
          end
        end else if (state_reg == PBSI_ST_ACTIVE) begin
          // Continuation cycle: second edge of a processor-strobe write or a burst beat
          do_write = wq;
          do_read = !wq;
          do_step = !step_n_reg;
        end
      end
      PBSI_ST_SLEEP: begin
        if (!sleep_sync_reg) begin
          state_next = PBSI_ST_DESEL;
        end
      end
      default: begin
        state_next = PBSI_ST_DESEL;
      end
    endcase
    acc_addr = load ? addr_reg : {base_reg, addr_low};
    lane_we = do_write ? pbsi_lane_mask(gw_n_reg, bwe_n_reg, bw_n_reg) : PBSI_NO_LANES;
  end

  // One-hot state register; a bad code falls back to deselected in decode
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg <= PBSI_ST_DESEL;
    end else if (i_ce) begin
      state_reg <= state_next;
    end
  end

  // Upper address bits stay fixed for the whole burst
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      base_reg <= '0;
    end else if (i_ce && load) begin
      base_reg <= addr_reg[PBSI_ADDR_W-1:PBSI_BURST_W];
    end
  end

  // Read pipeline flags; a pending read is dropped when sleep starts
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rd_valid_reg <= 1'h0;
    end else if (i_ce) begin
      rd_valid_reg <= do_read && (state_next != PBSI_ST_SLEEP);
    end
  end

  // Marks the first data cycle after leaving the deselected state
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      first_reg <= 1'h0;
    end else if (i_ce) begin
      first_reg <= do_read && (state_reg == PBSI_ST_DESEL);
    end
  end

  // A write seen last cycle keeps the drivers off while the master may still drive
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_cycle_reg <= 1'h0;
    end else if (i_ce) begin
      wr_cycle_reg <= do_write;
    end
  end

  // Low address bits of the current burst beat
  pbsi_burst_counter i_pbsi_burst_counter (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_load(load),
    .i_start(addr_reg[PBSI_BURST_W-1:0]),
    .i_step(do_step),
    .i_interleaved(order_reg),
    .o_addr_low(addr_low)
  );

  // Storage; read data lands in its output register
  pbsi_mem_array i_pbsi_mem_array (
    .i_clk(i_clk),
    .i_ce(i_ce),
    .i_lane_we(lane_we),
    .i_addr(acc_addr),
    .i_wdata(din_reg),
    .i_rd_en(do_read),
    .o_rdata(rdata)
  );

  assign o_dq = rdata;

  // Output enable is not sampled; write detection masks it so the bus never fights the master
  // Limitation: the master must still raise output enable before it drives write data
  always_comb begin
    o_dq_oe = 1'h0;
    if ((state_reg == PBSI_ST_ACTIVE) && rd_valid_reg) begin
      o_dq_oe = !first_reg && !i_out_enable_n;
      if (wr_cycle_reg || wq) begin
        o_dq_oe = 1'h0;
      end
    end
  end
  assign o_sleeping = (state_reg == PBSI_ST_SLEEP);
endmodule // pbsi_sram_if
`default_nettype wire

// ---- verif/pbsi_master_model.sv ----
// Bus master side of the shared data lines
`timescale 1ns/100ps
`default_nettype none
module pbsi_master_model
  import pbsi_pkg::*;
(
  // Clock and write data
  input wire logic i_clk,
  input wire logic i_drive,
  input wire logic [PBSI_DATA_W-1:0] i_wdata,
  // Memory driver state and bus
  input wire logic i_dev_oe,
  output logic [PBSI_DATA_W-1:0] o_bus
);
  logic [PBSI_DATA_W-1:0] last_reg;
  always_ff @(posedge i_clk) begin
    last_reg <= o_bus;
  end
  // Released lines flip every cycle so a stale word never looks valid
  assign o_bus = (i_drive && !i_dev_oe) ? i_wdata : ~last_reg;
endmodule // pbsi_master_model
`default_nettype wire

// ---- verif/pbsi_sram_if_props.sv ----
// Port assertions for the static memory interface
`timescale 1ns/100ps
`default_nettype none
module pbsi_sram_if_props
  import pbsi_pkg::*;
(
  // Clock, reset, selects, strobes
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_chip_sel1_n,
  input wire logic i_chip_sel2,
  input wire logic i_chip_sel3_n,
  input wire logic i_processor_addr_strobe_n,
  input wire logic i_controller_addr_strobe_n,
  // Write, enable, sleep, outputs
  input wire logic i_global_write_n,
  input wire logic i_byte_write_enable_n,
  input wire logic [PBSI_LANES-1:0] i_byte_lane_write_n,
  input wire logic i_out_enable_n,
  input wire logic i_sleep_request,
  input wire logic o_dq_oe,
  input wire logic o_sleeping
);
  logic chip_sel;
  logic write_qual;
  logic rd_req;
  logic desel_req;
  assign chip_sel = !i_chip_sel1_n && i_chip_sel2 && !i_chip_sel3_n;
  assign write_qual = !i_global_write_n || (!i_byte_write_enable_n && (i_byte_lane_write_n != 4'hF));
  assign rd_req = !i_controller_addr_strobe_n && i_processor_addr_strobe_n && chip_sel && !write_qual
                  && !i_sleep_request && !o_sleeping;
  assign desel_req = !i_controller_addr_strobe_n && !chip_sel;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  oe_gate_a: assert property (i_out_enable_n |-> !o_dq_oe)
    else $error("drivers on with output enable high");
  write_dark_a: assert property (write_qual |=> !o_dq_oe)
    else $error("drivers on during write");
  read_drive_a: assert property (rd_req ##1 (rd_req && !i_out_enable_n) ##1 (!i_out_enable_n && !write_qual) [*2]
    |-> o_dq_oe) else $error("read data not driven");
  desel_dark_a: assert property (desel_req |-> ##2 !o_dq_oe)
    else $error("drivers on after deselect");
  wake_dark_a: assert property (desel_req ##1 rd_req |-> ##2 !o_dq_oe)
    else $error("drivers on in first selected cycle");
  sleep_dark_a: assert property (o_sleeping |-> !o_dq_oe)
    else $error("drivers on in sleep");
  sleep_enter_a: assert property ($rose(i_sleep_request) |-> !o_sleeping ##1 !o_sleeping ##[1:3] o_sleeping)
    else $error("sleep entry timing");
  sleep_exit_a: assert property ($fell(i_sleep_request) |-> o_sleeping ##1 o_sleeping ##[1:3] !o_sleeping)
    else $error("sleep exit timing");
  cover property (rd_req ##1 rd_req);
  cover property (desel_req ##1 rd_req);
  cover property ($rose(o_sleeping));
endmodule // pbsi_sram_if_props
bind pbsi_sram_if pbsi_sram_if_props i_pbsi_sram_if_props (.i_clk, .i_rst_n, .i_chip_sel1_n, .i_chip_sel2,
  .i_chip_sel3_n, .i_processor_addr_strobe_n, .i_controller_addr_strobe_n, .i_global_write_n,
  .i_byte_write_enable_n, .i_byte_lane_write_n, .i_out_enable_n, .i_sleep_request, .o_dq_oe, .o_sleeping);
`default_nettype wire

// ---- verif/pbsi_sram_if_bench.sv ----
// Self-checking bench for the static memory interface
`timescale 1ns/100ps
`default_nettype none
module pbsi_sram_if_bench;
  import pbsi_pkg::*;
  localparam logic [PBSI_ADDR_W-1:0] ADDR_BASE = 19'h0_0010;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [PBSI_ADDR_W-1:0] addr = 19'h0_0000;
  logic cs1_n = 1'h0;
  logic cs2 = 1'h1;
  logic cs3_n = 1'h0;
  logic ce = 1'h1;
  logic pstb_n = 1'h1;
  logic cstb_n = 1'h1;
  logic step_n = 1'h1;
  logic order = 1'h0;
  logic allw_n = 1'h1;
  logic bytew_n = 1'h1;
  logic [PBSI_LANES-1:0] lane_n = 4'hF;
  logic oe_n = 1'h0;
  logic sleep = 1'h0;
  logic drive = 1'h0;
  logic oe_hold = 1'h0;
  logic [PBSI_DATA_W-1:0] wdata = 36'h0_0000_0000;
  logic [PBSI_DATA_W-1:0] bus;
  logic [PBSI_DATA_W-1:0] rdata;
  logic dq_oe;
  logic sleeping;
  logic [PBSI_DATA_W-1:0] w [4];
  int miscompares = 0;
  int cmp_count = 0;
  always #20 clk = ~clk;
  pbsi_sram_if i_pbsi_sram_if (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_addr(addr), .i_chip_sel1_n(cs1_n),
    .i_chip_sel2(cs2), .i_chip_sel3_n(cs3_n), .i_processor_addr_strobe_n(pstb_n), .i_controller_addr_strobe_n(cstb_n),
    .i_burst_step_n(step_n), .i_burst_order(order), .i_global_write_n(allw_n), .i_byte_write_enable_n(bytew_n),
    .i_byte_lane_write_n(lane_n), .i_out_enable_n(oe_n), .i_sleep_request(sleep), .i_dq(bus), .o_dq(rdata),
    .o_dq_oe(dq_oe), .o_sleeping(sleeping));
  pbsi_master_model i_pbsi_master_model (.i_clk(clk), .i_drive(drive), .i_wdata(wdata), .i_dev_oe(dq_oe),
    .o_bus(bus));
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [PBSI_DATA_W-1:0] got, input logic [PBSI_DATA_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One bus cycle; stb is {processor, controller} strobe
  task automatic put(input logic [1:0] stb, input logic [PBSI_ADDR_W-1:0] a, input logic aw_n, input logic bw_n,
                     input logic [PBSI_LANES-1:0] ln, input logic [PBSI_DATA_W-1:0] d);
    {pstb_n, cstb_n} = stb;
    addr = a;
    allw_n = aw_n;
    bytew_n = bw_n;
    lane_n = ln;
    wdata = d;
    drive = !aw_n || !bw_n;
    oe_n = drive && !oe_hold;
    cyc();
  endtask
  task automatic idle();
    put(2'h3, addr, 1'h1, 1'h1, 4'hF, 36'h0_0000_0000);
  endtask
  // Two back-to-back reads; the first word is out after the second edge
  task automatic rd(input logic [PBSI_ADDR_W-1:0] a, input logic [PBSI_DATA_W-1:0] exp);
    put(2'h2, a, 1'h1, 1'h1, 4'hF, 36'h0_0000_0000);
    put(2'h2, a, 1'h1, 1'h1, 4'hF, 36'h0_0000_0000);
    chk(rdata, exp);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #400_000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (12) cyc();
    rst_n = 1'h1;
    for (int i = 0; i < 4; i++) begin
      w[i] = 36'h9_1234_5670 + 36'(i);
      put(2'h2, ADDR_BASE + 19'(i), 1'h0, 1'h1, 4'hF, w[i]);
    end
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_BASE + 19'(i), w[i]);
      chk(36'(dq_oe), 36'h0_0000_0001);
    end
    $display("single access done");
    put(2'h2, ADDR_BASE, 1'h1, 1'h0, 4'hA, ~w[0]);
    w[0] = w[0] ^ 36'h0_07FC_01FF;
    rd(ADDR_BASE, w[0]);
    put(2'h2, ADDR_BASE + 19'h0_0001, 1'h1, 1'h1, 4'h0, ~w[1]);
    rd(ADDR_BASE + 19'h0_0001, w[1]);
    ce = 1'h0;
    rd(ADDR_BASE, w[1]);
    ce = 1'h1;
    $display("lane write done");
    oe_hold = 1'h1;
    put(2'h1, ADDR_BASE + 19'h0_0002, 1'h0, 1'h1, 4'hF, ~w[2]);
    chk(36'(dq_oe), 36'h0_0000_0000);
    oe_hold = 1'h0;
    rd(ADDR_BASE + 19'h0_0002, w[2]);
    put(2'h1, ADDR_BASE + 19'h0_0002, 1'h1, 1'h1, 4'hF, 36'h0_0000_0000);
    w[2] = 36'h5_5555_AAAA;
    put(2'h3, ADDR_BASE, 1'h0, 1'h1, 4'hF, w[2]);
    rd(ADDR_BASE + 19'h0_0002, w[2]);
    $display("two cycle write done");
    cs1_n = 1'h1;
    put(2'h1, ADDR_BASE + 19'h0_0003, 1'h1, 1'h1, 4'hF, 36'h0_0000_0000);
    cs1_n = 1'h0;
    w[2] = 36'h6_0606_0606;
    put(2'h3, ADDR_BASE, 1'h0, 1'h1, 4'hF, w[2]);
    rd(ADDR_BASE + 19'h0_0003, w[3]);
    rd(ADDR_BASE + 19'h0_0002, w[2]);
    $display("ignored strobe done");
    for (int m = 0; m < 2; m++) begin
      order = m[0];
      put(2'h2, ADDR_BASE + 19'h0_0001, 1'h1, 1'h1, 4'hF, 36'h0_0000_0000);
      step_n = 1'h0;
      idle();
      chk(rdata, w[1]);
      idle();
      for (int k = 1; k < 4; k++) begin
        idle();
        chk(rdata, w[m ? (1 ^ k) : ((1 + k) % 4)]);
      end
      step_n = 1'h1;
    end
    $display("burst order done");
    cs2 = 1'h0;
    put(2'h2, addr, 1'h1, 1'h1, 4'hF, 36'h0_0000_0000);
    idle();
    chk(36'(dq_oe), 36'h0_0000_0000);
    sleep = 1'h1;
    repeat (6) cyc();
    chk(36'(sleeping), 36'h0_0000_0001);
    sleep = 1'h0;
    repeat (6) cyc();
    chk(36'(sleeping), 36'h0_0000_0000);
    cs2 = 1'h1;
    cs3_n = 1'h1;
    put(2'h2, addr, 1'h1, 1'h1, 4'hF, 36'h0_0000_0000);
    cs3_n = 1'h0;
    rd(ADDR_BASE, w[0]);
    chk(36'(dq_oe), 36'h0_0000_0000);
    $display("sleep done");
    report_and_stop();
  end
endmodule // pbsi_sram_if_bench
`default_nettype wire
